// File: rtl/odc_pkg.sv
package odc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ                    = 10_000_000;
  localparam int SHUTDOWN_TIME_US          = 2500;
  localparam int MODE_DETECT_DELAY_US      = 100;
  localparam int MODE_DETECT_LOW_TIME_US   = 260;
  localparam int MODE_DETECT_WINDOW_US     = 1000;
  localparam int START_HIGH_TIME_US        = 3;
  localparam int END_OF_STREAM_TIME_US     = 3;
  localparam int BIT_SHORT_US              = 3;
  // Least times round up to whole cycles.
  localparam int SHUTDOWN_CYC     = (SHUTDOWN_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int DELAY_CYC        = (MODE_DETECT_DELAY_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int DETECT_LOW_CYC   = (MODE_DETECT_LOW_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int WINDOW_CYC       = (MODE_DETECT_WINDOW_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int START_CYC        = (START_HIGH_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int EOS_CYC          = (END_OF_STREAM_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int BIT_SHORT_CYC    = (BIT_SHORT_US * (CLK_HZ / 1000) + 999) / 1000;
  // ==========================================================================
  // Frame layout
  localparam logic [7:0] DEVICE_ADDR    = 8'h72;
  localparam int         ACK_REQ_POS    = 7;
  localparam int         SUB_ADDR_LSB   = 5;
  localparam int         CODE_W         = 5;
  localparam int         BYTE_W         = 8;
  localparam logic [4:0] CODE_FULL      = 5'h1F;
  // ==========================================================================
  // Host sequencer states
  typedef enum logic [3:0] {
    ODC_IDLE, ODC_DISABLE, ODC_WAKE, ODC_DET_DELAY, ODC_DET_LOW, ODC_ARMED,
    ODC_START, ODC_BIT_LOW, ODC_BIT_HIGH, ODC_EOS
  } odc_state_t;
endpackage : odc_pkg

// File: rtl/odc_host.sv
`timescale 1ns/10ps
// Host end of the single-wire dimming link: drives the enable pin to start the
// driver in either dimming mode, chops enable for duty-cycle dimming, and sends
// address and data frames in digital mode.
module odc_host #(
  parameter int SHUTDOWN_CYCLES = odc_pkg::SHUTDOWN_CYC,
  parameter int PWM_PERIOD      = 1000
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       start_pwm,
  input  wire logic       start_digital,
  input  wire logic       shut_down,
  input  wire logic       set_level,
  input  wire logic [4:0] level_code,
  input  wire logic [9:0] pwm_duty,
  output logic            en_pin,
  output logic            busy,
  output logic            digital_mode,
  output logic            pwm_mode,
  output logic            done
);
  // ==========================================================================
  // Parameter checks
  // Duty-cycle period must stay between 20 us and 100 us to keep enable lows
  // short of the mode detection low time.
  if (PWM_PERIOD < 200 || PWM_PERIOD > 1000 ||
      SHUTDOWN_CYCLES < odc_pkg::DETECT_LOW_CYC + 2) begin : g_bad_param
    $error("odc_host: parameter out of range");
  end
  // ==========================================================================
  // Bit slot timing: one slot is three short units, two units for the long part.
  localparam int UNIT  = odc_pkg::BIT_SHORT_CYC;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] C_ONE = CNT_W'(1);
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc
  odc_pkg::odc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0]       shift_r, shift_nxt;
  logic [2:0]       bit_r, bit_nxt;
  logic             second_r, second_nxt;
  logic [7:0]       data_r, data_nxt;
  logic             dig_r, dig_nxt;
  logic             pwm_r, pwm_nxt;
  logic             en_r, en_nxt;
  logic             done_r, done_nxt;
  logic [9:0]       duty_r;
  logic [9:0]       pwm_cnt_r;
  wire              cnt_zero = (cnt_r == '0);
  wire              cur_bit  = shift_r[7];
  // ones are short low then long high, zeros long low then short high.
  wire [CNT_W-1:0]  hi_len   = cur_bit ? cyc(2 * UNIT) : cyc(UNIT);
  wire [CNT_W-1:0]  lo_len   = cur_bit ? cyc(UNIT) : cyc(2 * UNIT);
  // ack bit zero, sub-address zero, code in the low bits.
  wire [7:0]        frame    = {1'b0, 2'b00, level_code};
  // duty-cycle chopping of enable while in duty-cycle mode.
  wire              pwm_high = (pwm_cnt_r < duty_r);
  // ==========================================================================
  // Sequencer
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    shift_nxt  = shift_r;
    bit_nxt    = bit_r;
    second_nxt = second_r;
    data_nxt   = data_r;
    dig_nxt    = dig_r;
    pwm_nxt    = pwm_r;
    en_nxt     = en_r;
    done_nxt   = 1'b0;
    if (!cnt_zero) begin
      cnt_nxt = cnt_r - C_ONE;
    end
    case (state_r)
      odc_pkg::ODC_IDLE: begin
        if (shut_down && (dig_r || pwm_r)) begin
          state_nxt = odc_pkg::ODC_DISABLE;
          cnt_nxt   = cyc(SHUTDOWN_CYCLES + 1);
          en_nxt    = 1'b0;
        end else if ((start_pwm || start_digital) && !dig_r && !pwm_r) begin
          // rising enable from shutdown, wait out the detect delay.
          state_nxt = start_digital ? odc_pkg::ODC_DET_DELAY : odc_pkg::ODC_WAKE;
          cnt_nxt   = cyc(odc_pkg::DELAY_CYC + UNIT);
          en_nxt    = 1'b1;
        end else if (set_level && dig_r) begin
          state_nxt  = odc_pkg::ODC_START;
          shift_nxt  = odc_pkg::DEVICE_ADDR;
          data_nxt   = frame;
          second_nxt = 1'b0;
          cnt_nxt    = cyc(odc_pkg::START_CYC);
          en_nxt     = 1'b1;
        end else if (pwm_r) begin
          en_nxt = pwm_high;
        end
      end
      odc_pkg::ODC_DISABLE: begin
        // hold low past the shutdown time so the mode can be chosen anew.
        // The mode flags drop only once the driver has really shut down.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_IDLE;
          done_nxt  = 1'b1;
          dig_nxt   = 1'b0;
          pwm_nxt   = 1'b0;
        end
      end
      odc_pkg::ODC_WAKE: begin
        // first chop only after the detect delay; lows stay short after for any nonzero duty.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_IDLE;
          pwm_nxt   = 1'b1;
          done_nxt  = 1'b1;
        end
      end
      odc_pkg::ODC_DET_DELAY: begin
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_DET_LOW;
          cnt_nxt   = cyc(odc_pkg::DETECT_LOW_CYC + UNIT);
          en_nxt    = 1'b0;
        end
      end
      odc_pkg::ODC_DET_LOW: begin
        // low longer than the detect time, released well inside the window.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_ARMED;
          cnt_nxt   = cyc(odc_pkg::START_CYC);
          en_nxt    = 1'b1;
        end
      end
      odc_pkg::ODC_ARMED: begin
        // done comes after the start high time so the first frame can follow well inside 2 ms.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_IDLE;
          dig_nxt   = 1'b1;
          done_nxt  = 1'b1;
        end
      end
      odc_pkg::ODC_START: begin
        // start condition high before the first falling edge.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_BIT_LOW;
          bit_nxt   = 3'd0;
          cnt_nxt   = lo_len;
          en_nxt    = 1'b0;
        end
      end
      odc_pkg::ODC_BIT_LOW: begin
        // each bit begins at a falling edge, low part first.
        if (cnt_zero) begin
          state_nxt = odc_pkg::ODC_BIT_HIGH;
          cnt_nxt   = hi_len;
          en_nxt    = 1'b1;
        end
      end
      odc_pkg::ODC_BIT_HIGH: begin
        if (cnt_zero) begin
          shift_nxt = {shift_r[6:0], 1'b0};
          bit_nxt   = bit_r + 3'd1;
          en_nxt    = 1'b0;
          if (bit_r == 3'd7) begin
            state_nxt = odc_pkg::ODC_EOS;
            cnt_nxt   = cyc(odc_pkg::EOS_CYC);
          end else begin
            state_nxt = odc_pkg::ODC_BIT_LOW;
            cnt_nxt   = shift_r[6] ? cyc(UNIT) : cyc(2 * UNIT);
          end
        end
      end
      odc_pkg::ODC_EOS: begin
        // end of stream low closes the byte; then the data byte.
        if (cnt_zero) begin
          en_nxt = 1'b1;
          if (!second_r) begin
            state_nxt  = odc_pkg::ODC_START;
            second_nxt = 1'b1;
            shift_nxt  = data_r;
            cnt_nxt    = cyc(odc_pkg::START_CYC);
          end else begin
            state_nxt = odc_pkg::ODC_IDLE;
            done_nxt  = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = odc_pkg::ODC_IDLE;
        en_nxt    = 1'b0;
      end
    endcase
  end
  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r   <= odc_pkg::ODC_IDLE;
      cnt_r     <= '0;
      shift_r   <= 8'h00;
      bit_r     <= 3'h0;
      second_r  <= 1'b0;
      data_r    <= 8'h00;
      dig_r     <= 1'b0;
      pwm_r     <= 1'b0;
      en_r      <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      bit_r     <= bit_nxt;
      second_r  <= second_nxt;
      data_r    <= data_nxt;
      dig_r     <= dig_nxt;
      pwm_r     <= pwm_nxt;
      en_r      <= en_nxt;
      done_r    <= done_nxt;
    end
  end
  // Duty value is taken once per period so a change never makes a runt pulse.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwm_cnt_r <= 10'h000;
      duty_r    <= 10'h000;
    end else if (pwm_cnt_r == 10'(PWM_PERIOD - 1)) begin
      pwm_cnt_r <= 10'h000;
      duty_r    <= (pwm_duty > 10'(PWM_PERIOD)) ? 10'(PWM_PERIOD) : pwm_duty;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 10'h001;
    end
  end
  assign en_pin       = en_r;
  assign busy         = (state_r != odc_pkg::ODC_IDLE);
  assign digital_mode = dig_r;
  assign pwm_mode     = pwm_r;
  assign done         = done_r;
endmodule : odc_host

// File: verif/odc_dev_model.sv
`timescale 1ns/10ps
// ============================================================
// Enable pin decoder of the driver; the analog loop is not modelled.
module odc_dev_model #(
  parameter int OFF_CYC = odc_pkg::SHUTDOWN_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       en_pin,
  output logic            dev_on,
  output logic            dev_dig,
  output logic [4:0]      dev_code,
  output logic            dev_bad
);
  logic [15:0] lo_r, hi_r, lo_len_r, t_r;
  logic [7:0]  sh_r;
  logic [3:0]  nf_r;
  logic        en_s_r, sec_r, adr_ok_r;
  // Only the ratio of high and low counts matters, so any bit rate with lows shorter than OFF_CYC decodes.
  wire         one  = hi_r >= 2 * lo_len_r;
  wire         zero = lo_len_r >= 2 * hi_r;
  wire [7:0]   byt  = {sh_r[6:0], one};
  wire         fall = en_s_r && !en_pin;
  wire         rise = !en_s_r && en_pin;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {en_s_r, lo_r, hi_r, lo_len_r, t_r, sh_r, nf_r, sec_r, adr_ok_r} <= '0;
      {dev_on, dev_dig, dev_bad} <= 3'h0;
      dev_code <= odc_pkg::CODE_FULL;
    end else begin
      en_s_r <= en_pin;
      lo_r <= en_pin ? 16'h0 : lo_r + 16'h1;
      hi_r <= en_pin ? hi_r + 16'h1 : 16'h0;
      if (t_r != 16'hFFFF) t_r <= t_r + 16'h1;
      if (rise) lo_len_r <= lo_r;
      if (lo_r == 16'(OFF_CYC - 1)) {dev_on, dev_dig} <= 2'h0;
      if (rise && !dev_on) begin
        dev_on <= 1'b1;
        {t_r, nf_r, sec_r} <= '0;
      end
      if (rise && dev_on && !dev_dig && lo_r >= odc_pkg::DETECT_LOW_CYC &&
          t_r < odc_pkg::WINDOW_CYC && t_r - lo_r >= odc_pkg::DELAY_CYC) dev_dig <= 1'b1;
      if (fall && dev_dig) begin
        nf_r <= (nf_r == 4'h8) ? 4'h0 : nf_r + 4'h1;
        if (nf_r != 4'h0) begin
          sh_r <= byt;
          if (!one && !zero) dev_bad <= 1'b1;
        end
        if (nf_r == 4'h8) begin
          sec_r <= !sec_r;
          if (!sec_r) adr_ok_r <= byt == odc_pkg::DEVICE_ADDR;
          else if (adr_ok_r && byt[6:5] == 2'h0) dev_code <= byt[4:0];
        end
      end
    end
  end
endmodule : odc_dev_model

// File: verif/odc_host_sva.sv
`timescale 1ns/10ps
module odc_host_sva #(
  parameter int SHUTDOWN_CYCLES = odc_pkg::SHUTDOWN_CYC
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       start_pwm,
  input wire logic       start_digital,
  input wire logic       shut_down,
  input wire logic       set_level,
  input wire logic [4:0] level_code,
  input wire logic [9:0] pwm_duty,
  input wire logic       en_pin,
  input wire logic       busy,
  input wire logic       digital_mode,
  input wire logic       pwm_mode,
  input wire logic       done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ============================================================
  // Low run lengths; the last one is kept for the mode pattern.
  logic [15:0] lo_c_r, last_lo_r;
  wire         no_mode = !digital_mode && !pwm_mode;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lo_c_r    <= 16'h0;
      last_lo_r <= 16'h0;
    end else begin
      lo_c_r <= en_pin ? 16'h0 : lo_c_r + 16'h1;
      if (en_pin && lo_c_r != 16'h0) last_lo_r <= lo_c_r;
    end
  end
  reset_quiet_a: assert property ($fell(sys_rst) |-> !en_pin && !busy && no_mode)
    else $error("outputs active after reset");
  mode_excl_a: assert property (!(digital_mode && pwm_mode))
    else $error("both modes active");
  mode_drop_a: assert property (($fell(digital_mode) || $fell(pwm_mode)) && !$past(sys_rst)
    |-> lo_c_r >= SHUTDOWN_CYCLES / 2) else $error("mode left without long low");
  dig_entry_a: assert property ($rose(digital_mode) |-> last_lo_r >= 16'd2600 &&
    last_lo_r < SHUTDOWN_CYCLES) else $error("digital mode without detect low");
  pwm_hold_a: assert property (pwm_mode && !busy && !shut_down |=> !busy)
    else $error("request taken in duty mode");
  dig_high_a: assert property (digital_mode && !busy && !$past(busy) |-> en_pin)
    else $error("enable low while digital idle");
  frame_start_a: assert property (digital_mode && !busy && set_level && !shut_down
    |=> (busy && en_pin)[*8]) else $error("frame start high missing");
  wake_high_a: assert property ((start_pwm || start_digital) && !busy && no_mode &&
    !shut_down |=> ##1 en_pin[*8]) else $error("enable not raised on start");
  shut_low_a: assert property (shut_down && !busy && !no_mode |=> ##1 (!en_pin)[*8])
    else $error("enable not low on shutdown");
  cover property ($rose(digital_mode));
  cover property ($rose(pwm_mode));
  cover property ($fell(digital_mode));
endmodule : odc_host_sva

// File: verif/test_one_wire_dimming_control.sv
`timescale 1ns/10ps
module test_one_wire_dimming_control;
  localparam int SHUT = 3000;
  localparam int PER  = 200;
  logic        core_clk = 0, sys_rst = 1, start_pwm = 0, start_digital = 0;
  logic        shut_down = 0, set_level = 0;
  logic [4:0]  level_code = 5'h00, c;
  logic [9:0]  pwm_duty = 10'h000;
  logic        en_pin, busy, digital_mode, pwm_mode, done, dev_on, dev_dig, dev_bad;
  logic [4:0]  dev_code;
  logic [31:0] seed = 32'h1BC301F4;
  int          error_cnt = 0, checks_done = 0, hi;
  always #50 core_clk = ~core_clk;
  odc_host #(.SHUTDOWN_CYCLES(SHUT), .PWM_PERIOD(PER)) u_odc_host (.core_clk, .sys_rst,
    .start_pwm, .start_digital, .shut_down, .set_level, .level_code, .pwm_duty, .en_pin,
    .busy, .digital_mode, .pwm_mode, .done);
  odc_dev_model #(.OFF_CYC(SHUT)) u_odc_dev_model (.core_clk, .sys_rst, .en_pin, .dev_on,
    .dev_dig, .dev_code, .dev_bad);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask : chk
  // A refused request is judged by busy staying low half a cycle after it was taken.
  task req(input int k, input logic [4:0] code, input bit wait_done);
    int n;
    @(negedge core_clk);
    {shut_down, start_digital, start_pwm, set_level} = 4'h1 << k;
    level_code = code;
    @(negedge core_clk);
    {shut_down, start_digital, start_pwm, set_level} = 4'h0;
    for (n = 0; wait_done && n < 20000 && done !== 1'b1; n++) @(negedge core_clk);
    chk(wait_done ? done : busy, 16'(wait_done), "handshake");
  endtask : req
  task finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 0;
    chk(en_pin, 0, "enable after reset");
    req(0, 5'h03, 0);
    req(1, 5'h00, 1);
    chk({pwm_mode, dev_on, dev_dig}, 3'b110, "duty start");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pwm_duty = (i == 0) ? 10'h000 : (i == 1) ? 10'(PER) : (i == 2) ? 10'h3FF : 10'(seed % PER);
      repeat (2 * PER) @(negedge core_clk);
      hi = 0;
      repeat (PER) begin
        @(negedge core_clk);
        hi += int'(en_pin);
      end
      chk(16'(hi), (pwm_duty > PER) ? 16'(PER) : 16'(pwm_duty), "duty high count");
    end
    req(2, 5'h00, 0);
    chk(dev_dig, 0, "mode change in duty mode");
    req(3, 5'h00, 1);
    chk({dev_on, pwm_mode}, 2'b00, "shutdown");
    req(2, 5'h00, 1);
    chk({digital_mode, dev_dig, dev_code}, {2'b11, 5'h1F}, "digital start");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : seed[4:0];
      req(0, c, 1);
      chk(dev_code, c, "level code");
    end
    chk(dev_bad, 0, "bit shape");
    req(1, 5'h00, 0);
    chk(pwm_mode, 0, "duty start in digital");
    req(3, 5'h00, 1);
    chk(dev_dig, 0, "digital shutdown");
    req(1, 5'h00, 1);
    chk({dev_dig, dev_code}, {1'b0, c}, "fresh duty start");
    finish_test;
  end
  initial begin
    #5000000;
    error_cnt++;
    finish_test;
  end
endmodule : test_one_wire_dimming_control
bind odc_host odc_host_sva #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) u_odc_host_sva (.core_clk,
  .sys_rst, .start_pwm, .start_digital, .shut_down, .set_level, .level_code, .pwm_duty,
  .en_pin, .busy, .digital_mode, .pwm_mode, .done);
